// ### boot_sel_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the package, the top module and the bench only
`ifndef BOOT_SEL_REGS_SVH
`define BOOT_SEL_REGS_SVH

`define CFG_OFFSET 5'h00
`define IE_OFFSET 5'h04
`define CMD_OFFSET 5'h08
`define STATUS_OFFSET 5'h0C
`define LATCH_OFFSET 5'h10

`define CFG_LDR_LSB 0
`define CFG_BD_LSB 8
`define CFG_SEL_LSB 16
`define CFG_LVL_BIT 24
`define CMD_SHUTDOWN_BIT 0

`define ENABLE_KEY 8'hC5
`define LEVEL_ACTIVE_LOW 1'h0
`define CFG_RESET 32'h0000_0000
`define IE_RESET 32'h0000_0000

`define CLK_PERIOD_NS 40
`define WAKE_RESET_NS 400
`define WAKE_RESET_CYCLES ((`WAKE_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### boot_sel_pkg.sv
// Types shared by the boot selection block
// Assumes the constants header is available by bare name
package boot_sel_pkg;
   `include "boot_sel_regs.svh"

   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_SHUTDOWN = 3'b001,
      ST_WAKE_RESET = 3'b010,
      ST_DECIDE = 3'b011
   } pwr_state_e;

   typedef struct packed {
      logic [7:0] loader_enable_field;
      logic [7:0] pin_backdoor_enable_field;
      logic [7:0] backdoor_pin_select;
      logic backdoor_active_level;
   } boot_cfg_s;

   typedef struct packed {
      logic to_loader;
      logic wake_by_tck;
      logic decided;
      logic in_shutdown;
   } boot_status_s;
endpackage : boot_sel_pkg

// ### sync2.sv
// Two-flop synchroniser for asynchronous pin levels
// Assumes the pins are slow levels; no pulse stretching is done
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : sync2

// ### pad_latch.sv
// Pad input gating and shutdown latch of the general I/O levels
// Assumes pin levels are already synchronised to clk
`timescale 1ns/1ps
module pad_latch #(
   parameter int NUM_PINS = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_PINS-1:0] pin_level,
   input wire logic [NUM_PINS-1:0] pad_input_buffer_enable,
   input wire logic latch_en,
   output logic [NUM_PINS-1:0] latched_q
);
   logic [NUM_PINS-1:0] gated;
   logic [NUM_PINS-1:0] latched_d;

   // Disabled buffer reads constant zero
   assign gated = pin_level & pad_input_buffer_enable;

   always_comb begin
      latched_d = latched_q;
      if (latch_en) begin
         latched_d = gated;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latched_q <= '0;
      end else begin
         latched_q <= latched_d;
      end
   end
endmodule : pad_latch

// ### boot_sel.sv
// Shutdown wake boot path selection with Avalon-MM register access
// Assumes one clock; pins and wake sources are asynchronous to clk
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "boot_sel_regs.svh"
module boot_sel
   import boot_sel_pkg::*;
#(
   parameter int NUM_PINS = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [NUM_PINS-1:0] general_io_pin,
   input wire logic tck_pin,
   input wire logic gpio_wake_pin,
   output logic core_reset,
   output logic in_shutdown,
   output logic boot_to_loader,
   output logic boot_done
);
   localparam int WAKE_CYCLES = `WAKE_RESET_CYCLES;
   localparam int CNT_W = $clog2(WAKE_CYCLES + 1);

   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_be

   // Synchronised pins
   logic [NUM_PINS-1:0] pins_s;
   logic tck_s;
   logic gpio_wake_s;

   sync2 #(.WIDTH(NUM_PINS)) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .async_in(general_io_pin),
      .sync_out(pins_s)
   );

   sync2 #(.WIDTH(2)) u_wake_sync (
      .clk(clk),
      .rst(rst),
      .async_in({tck_pin, gpio_wake_pin}),
      .sync_out({tck_s, gpio_wake_s})
   );

   // Register and bus state
   logic [31:0] cfg_q, cfg_d;
   logic [NUM_PINS-1:0] ie_q, ie_d;
   logic shut_req_q, shut_req_d;
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   boot_cfg_s cfg;
   boot_status_s status;
   logic [NUM_PINS-1:0] latched_q;
   logic [31:0] latched_word;
   logic [31:0] ie_word;
   logic bus_req;
   logic wr_take;

   // Machine state
   pwr_state_e state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic tck_prev_q, tck_prev_d;
   logic gpio_prev_q, gpio_prev_d;
   logic by_tck_q, by_tck_d;
   logic loader_q, loader_d;
   logic decided_q, decided_d;
   logic done_q, done_d;
   logic core_rst_q, core_rst_d;
   logic latch_en;
   logic tck_edge;
   logic gpio_edge;
   logic sel_ok;
   logic sel_level;
   logic backdoor_hit;

   assign cfg.loader_enable_field = cfg_q[`CFG_LDR_LSB +: 8];
   assign cfg.pin_backdoor_enable_field = cfg_q[`CFG_BD_LSB +: 8];
   assign cfg.backdoor_pin_select = cfg_q[`CFG_SEL_LSB +: 8];
   assign cfg.backdoor_active_level = cfg_q[`CFG_LVL_BIT];

   assign status.to_loader = loader_q;
   assign status.wake_by_tck = by_tck_q;
   assign status.decided = decided_q;
   assign status.in_shutdown = (state_q == ST_SHUTDOWN);

   // Pad latch keeps the levels seen on the way into shutdown
   assign latch_en = (state_q == ST_RUN) && shut_req_q;

   pad_latch #(.NUM_PINS(NUM_PINS)) u_pad_latch (
      .clk(clk),
      .rst(rst),
      .pin_level(pins_s),
      .pad_input_buffer_enable(ie_q),
      .latch_en(latch_en),
      .latched_q(latched_q)
   );

   always_comb begin
      latched_word = '0;
      ie_word = '0;
      latched_word[NUM_PINS-1:0] = latched_q;
      ie_word[NUM_PINS-1:0] = ie_q;
   end

   // Out-of-range selects never match, so they boot the application
   assign sel_ok = cfg.backdoor_pin_select < NUM_PINS;
   assign sel_level = sel_ok ?
      latched_q[cfg.backdoor_pin_select[$clog2(NUM_PINS)-1:0]] : 1'b0;

   // Buffer-off pins read zero, so active low matches them
   assign backdoor_hit = (cfg.loader_enable_field == `ENABLE_KEY) &&
      (cfg.pin_backdoor_enable_field == `ENABLE_KEY) &&
      sel_ok &&
      (sel_level == cfg.backdoor_active_level);

   assign tck_edge = tck_s ^ tck_prev_q;
   assign gpio_edge = gpio_wake_s ^ gpio_prev_q;

   // Bus slave: one wait cycle, then answer with waitrequest low
   assign bus_req = avs_read || avs_write;
   assign wr_take = avs_write && !wait_q;

   always_comb begin
      wait_d = 1'b1;
      rdata_d = rdata_q;
      cfg_d = cfg_q;
      ie_d = ie_q;
      shut_req_d = shut_req_q;
      if (bus_req && wait_q) begin
         wait_d = 1'b0;
         rdata_d = 32'h0000_0000;
         if (avs_read) begin
            case (avs_address)
               `CFG_OFFSET: rdata_d = cfg_q & 32'h01FF_FFFF;
               `IE_OFFSET: rdata_d = ie_word;
               `STATUS_OFFSET: rdata_d = {28'h0000000, status};
               `LATCH_OFFSET: rdata_d = latched_word;
               default: rdata_d = 32'h0000_0000;
            endcase
         end
      end
      // Consumed on shutdown entry; a command written then still wins
      if (latch_en) begin
         shut_req_d = 1'b0;
      end
      if (wr_take) begin
         case (avs_address)
            `CFG_OFFSET: begin
               cfg_d = merge_be(cfg_q, avs_writedata, avs_byteenable)
                       & 32'h01FF_FFFF;
            end
            `IE_OFFSET: begin
               ie_d = merge_be(ie_word, avs_writedata,
                               avs_byteenable) & {NUM_PINS{1'b1}};
            end
            `CMD_OFFSET: begin
               if (avs_byteenable[0] && avs_writedata[`CMD_SHUTDOWN_BIT]) begin
                  shut_req_d = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         cfg_q <= `CFG_RESET;
         ie_q <= '0;
         shut_req_q <= 1'b0;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         cfg_q <= cfg_d;
         ie_q <= ie_d;
         shut_req_q <= shut_req_d;
      end
   end

   // Power mode sequence
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      tck_prev_d = tck_s;
      gpio_prev_d = gpio_wake_s;
      by_tck_d = by_tck_q;
      loader_d = loader_q;
      decided_d = decided_q;
      done_d = 1'b0;
      core_rst_d = core_rst_q;
      case (state_q)
         ST_RUN: begin
            if (shut_req_q) begin
               state_d = ST_SHUTDOWN;
               core_rst_d = 1'b1;
               decided_d = 1'b0;
            end
         end
         ST_SHUTDOWN: begin
            // Pin event has priority when both arrive together
            if (gpio_edge) begin
               by_tck_d = 1'b0;
               state_d = ST_WAKE_RESET;
               cnt_d = CNT_W'(WAKE_CYCLES);
            end else if (tck_edge) begin
               by_tck_d = 1'b1;
               state_d = ST_WAKE_RESET;
               cnt_d = CNT_W'(WAKE_CYCLES);
            end
         end
         ST_WAKE_RESET: begin
            if (cnt_q <= CNT_W'(1)) begin
               state_d = ST_DECIDE;
            end else begin
               cnt_d = cnt_q - CNT_W'(1);
            end
         end
         ST_DECIDE: begin
            // Only the faulty TCK wake ever reaches the loader
            loader_d = by_tck_q && backdoor_hit;
            decided_d = 1'b1;
            done_d = 1'b1;
            core_rst_d = 1'b0;
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_RUN;
            core_rst_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_RUN;
         cnt_q <= '0;
         tck_prev_q <= 1'b0;
         gpio_prev_q <= 1'b0;
         by_tck_q <= 1'b0;
         loader_q <= 1'b0;
         decided_q <= 1'b0;
         done_q <= 1'b0;
         core_rst_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         tck_prev_q <= tck_prev_d;
         gpio_prev_q <= gpio_prev_d;
         by_tck_q <= by_tck_d;
         loader_q <= loader_d;
         decided_q <= decided_d;
         done_q <= done_d;
         core_rst_q <= core_rst_d;
      end
   end

   logic shut_out_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shut_out_q <= 1'b0;
      end else begin
         shut_out_q <= (state_d == ST_SHUTDOWN);
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign core_reset = core_rst_q;
   assign in_shutdown = shut_out_q;
   assign boot_to_loader = loader_q;
   assign boot_done = done_q;
endmodule : boot_sel

// ### pin_drv.sv
// Partner model: external pin driver and debug probe on the pin side
// Assumes the bench asks for levels and toggles at the rising clock edge
`timescale 1ns/1ps
module pin_drv (
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] level_req,
   input wire logic tck_kick,
   input wire logic gpio_kick,
   output logic [31:0] general_io_pin,
   output logic tck_pin,
   output logic gpio_wake_pin
);
   // Pins are plain levels; wakes are single edges, not free-running clocks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         general_io_pin <= 32'h0000_0000;
         tck_pin <= 1'h0;
         gpio_wake_pin <= 1'h0;
      end else begin
         general_io_pin <= level_req;
         if (tck_kick) tck_pin <= ~tck_pin;
         if (gpio_kick) gpio_wake_pin <= ~gpio_wake_pin;
      end
   end
endmodule : pin_drv

// ### boot_sel_chk.sv
// Checker: bus handshake and wake sequencing at the boot_sel ports
// Assumes one clock and active-high reset; bound into boot_sel below
`timescale 1ns/1ps
module boot_sel_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic core_reset,
   input wire logic in_shutdown,
   input wire logic boot_to_loader,
   input wire logic boot_done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_ack;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_ack_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   property p_done_pulse;
      boot_done |=> !boot_done;
   endproperty
   property p_shut_reset;
      $rose(in_shutdown) |-> core_reset;
   endproperty
   property p_reset_cause;
      $rose(core_reset) |-> $rose(in_shutdown);
   endproperty
   property p_wake_time;
      $fell(in_shutdown) |-> !boot_done [*8] ##[1:5] boot_done;
   endproperty
   property p_release;
      boot_done |-> !core_reset && $past(core_reset);
   endproperty
   property p_result_held;
      !boot_done |-> $stable(boot_to_loader);
   endproperty
   property p_no_done_asleep;
      in_shutdown |-> core_reset && !boot_done;
   endproperty
   a_ack: assert property (p_ack) else $error("no answer");
   a_ack_one: assert property (p_ack_one) else $error("long ack");
   a_done_pulse: assert property (p_done_pulse) else $error("done");
   a_shut_reset: assert property (p_shut_reset) else $error("rst");
   a_reset_cause: assert property (p_reset_cause) else $error("cause");
   a_wake_time: assert property (p_wake_time) else $error("wake");
   a_release: assert property (p_release) else $error("release");
   a_result_held: assert property (p_result_held) else $error("held");
   a_no_done_asleep: assert property (p_no_done_asleep) else $error("sd");
   c_loader: cover property (boot_done && boot_to_loader);
   c_app: cover property (boot_done && !boot_to_loader);
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule : boot_sel_chk
bind boot_sel boot_sel_chk i_boot_sel_chk (.clk(clk), .rst(rst),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .core_reset(core_reset),
   .in_shutdown(in_shutdown), .boot_to_loader(boot_to_loader),
   .boot_done(boot_done));

// ### boot_sel_test.sv
// Testbench: registers over Avalon-MM, then shutdown and wake cases
// Assumes boot_sel, pin_drv and the checker are compiled before it
`timescale 1ns/1ps
`include "boot_sel_regs.svh"
module boot_sel_test;
   import boot_sel_pkg::*;
   logic clk = 0, rst = 1, rd = 0, wr = 0, tk = 0, gk = 0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wd = 32'h0, lvl = 32'h0, d;
   logic [3:0] be = 4'hF;
   logic [31:0] rdata, pins;
   logic wait_q, tck, gpio, core_rst, sd, ldr, done;
   int n_errors = 0, checked = 0, cyc = 0;
   always #20 clk = ~clk;
   boot_sel i_boot_sel (.clk(clk), .rst(rst), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_q),
      .general_io_pin(pins), .tck_pin(tck), .gpio_wake_pin(gpio),
      .core_reset(core_rst), .in_shutdown(sd), .boot_to_loader(ldr),
      .boot_done(done));
   pin_drv i_pin_drv (.clk(clk), .rst(rst), .level_req(lvl), .tck_kick(tk),
      .gpio_kick(gk), .general_io_pin(pins), .tck_pin(tck),
      .gpio_wake_pin(gpio));
   task wrap_up;
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // Request held until waitrequest is sampled low, then released
   task bus(input logic w, input logic [4:0] a, input logic [31:0] v);
      int n;
      n = 0;
      addr <= a;
      wd <= v;
      rd <= !w;
      wr <= w;
      @(posedge clk);
      while (wait_q !== 1'b0 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) begin
         chk("waitrequest", 32'h0, 32'(wait_q));
         wrap_up();
      end
      d = rdata;
      rd <= 0;
      wr <= 0;
      @(posedge clk);
   endtask : bus
   task t_regs;
      logic [4:0] a;
      bus(1, 5'h0C, 32'hFFFF_FFFF);
      bus(1, 5'h14, 32'hFFFF_FFFF);
      for (int i = 0; i < 6; i++) begin
         a = 5'(i * 4);
         bus(0, a, 32'h0);
         chk("reset read", 32'h0, d);
      end
      bus(1, 5'h00, 32'hFFFF_FFFF);
      be <= 4'h1;
      bus(1, 5'h00, 32'h0);
      be <= 4'hF;
      bus(0, 5'h00, 32'h0);
      chk("cfg", 32'h01FF_FF00, d);
   endtask : t_regs
   // Levels set, shutdown entered, optional pin change, then one wake
   task wake(input logic [31:0] cfg, ie, p, input logic by_tck, flip, exp);
      int n;
      bus(1, 5'h00, cfg);
      bus(1, 5'h04, ie);
      lvl <= p;
      repeat (4) @(posedge clk);
      bus(1, 5'h08, 32'h1);
      n = 0;
      while (sd !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      chk("in_shutdown", 32'h1, 32'(sd));
      chk("core_reset", 32'h1, 32'(core_rst));
      if (flip) lvl <= ~p;
      if (by_tck) tk <= 1;
      else gk <= 1;
      @(posedge clk);
      tk <= 0;
      gk <= 0;
      n = 0;
      while (done !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      chk("boot_done", 32'h1, 32'(done));
      // Counted after the pin register: two sync flops, edge detect, hold, decide, sample
      chk("wake cycles", 32'(`WAKE_RESET_CYCLES + 5), 32'(n));
      chk("core_reset", 32'h0, 32'(core_rst));
      chk("in_shutdown", 32'h0, 32'(sd));
      chk("boot_to_loader", 32'(exp), 32'(ldr));
      bus(0, 5'h10, 32'h0);
      chk("latch", p & ie, d);
   endtask : wake
   // Reset in mid-run: result and configuration return to zero
   task t_reset;
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      chk("reset boot_to_loader", 32'h0, 32'(ldr));
      chk("reset core_reset", 32'h0, 32'(core_rst));
      bus(0, 5'h00, 32'h0);
      chk("reset cfg", 32'h0, d);
   endtask : t_reset
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_errors++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      t_regs();
      wake(32'h0003_C5C5, 32'h0, 32'h8, 1, 0, 1);
      wake(32'h0003_C5C5, 32'h0, 32'h8, 0, 0, 0);
      wake(32'h0003_C5C4, 32'h0, 32'h0, 1, 0, 0);
      wake(32'h0003_00C5, 32'h0, 32'h0, 1, 0, 0);
      wake(32'h0105_C5C5, 32'h20, 32'h20, 1, 0, 1);
      wake(32'h0105_C5C5, 32'h60, 32'h40, 1, 0, 0);
      wake(32'h0105_C5C5, 32'h20, 32'h20, 1, 1, 1);
      t_reset();
      wake(32'h0105_C5C5, 32'h0, 32'h20, 1, 0, 0);
      wrap_up();
   end
endmodule : boot_sel_test
